//--- rtl/frm_regs.svh
// register offsets, reset values and counts of the fifo reset/config block
`ifndef FRM_REGS_SVH
`define FRM_REGS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define FRM_REG_CONTROL      4'h0
`define FRM_REG_STATUS       4'h4
`define FRM_REG_OFFSETS      4'h8
`define FRM_REG_LEVEL        4'hc

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FRM_CTL_SIZE_LSB     0
`define FRM_ST_FIR           0
`define FRM_ST_EOR           1
`define FRM_ST_AE_N          2
`define FRM_ST_AF_N          3
`define FRM_ST_MBA_N         4
`define FRM_ST_MBB_N         5
`define FRM_ST_FALL_THROUGH_MODE_A        6
`define FRM_ST_FALL_THROUGH_MODE_B        7
`define FRM_ST_BIG           8
`define FRM_ST_PROG_LSB      9
`define FRM_ST_PHASE_LSB     12
`define FRM_OFS_X_LSB        0
`define FRM_OFS_Y_LSB        16

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define FRM_CTL_RESET        2'h0
`define FRM_RESET_EDGES      3'h4
`define FRM_RELEASE_EDGES    2'h2
`define FRM_PARALLEL_LOADS   2'h2
`define FRM_PRESET_64        16'h0040
`define FRM_PRESET_16        16'h0010
`define FRM_PRESET_8         16'h0008
`define FRM_PROG_P64         3'h7
`define FRM_PROG_P16         3'h6
`define FRM_PROG_P8          3'h5
`define FRM_PROG_PARALLEL    3'h4
`define FRM_PROG_SERIAL      3'h2

`endif

//--- rtl/frm_pkg.sv
// types shared by the fifo reset/config block
package frm_pkg;

	// reset sequencing phases, one-hot
	typedef enum logic [2:0] {
		FRM_PH_HOLD = 3'b001,
		FRM_PH_WAKE = 3'b010,
		FRM_PH_RUN  = 3'b100
	} frm_phase_type;

	// port b bus width
	typedef enum logic [1:0] {
		FRM_SIZE_36 = 2'h0,
		FRM_SIZE_18 = 2'h1,
		FRM_SIZE_9  = 2'h2
	} frm_size_type;

endpackage

//--- rtl/frm_fifo_reset_config.sv
// fifo with reset, partial flush and power-up configuration logic
//
// Operation
// (RULE_01) pulse both resets low together once after power-up
// (RULE_02) full reset acts only if held across four edges of each port clock
// (RULE_03) reset inputs may change at any time
// (RULE_04) full reset clears pointers, drops both ready flags
// (RULE_05) reset forces almost-empty low, almost-full high, mail flags high
// (RULE_06) primary reset clears a-to-b mail, secondary clears b-to-a mail
// (RULE_07) full/ready rises two port a edges after full reset ends
// (RULE_08) primary reset rising edge captures endian select as byte order
// (RULE_09) same edge captures flag and serial selects as method
// (RULE_10) select code picks preset 64, 16, 8, parallel, serial or reserved
// (RULE_11) parallel: first two writes load almost-full, then almost-empty
// (RULE_12) partial flush acts if held across four edges of each port clock
// (RULE_13) partial flush clears pointers, forces flags like a reset
// (RULE_14) full/ready rises two port a edges after partial flush ends
// (RULE_15) partial flush keeps offsets, method and timing mode
// (RULE_16) big endian: most significant unit leaves port b first
// (RULE_17) little endian: least significant unit leaves port b first
// (RULE_18) full 36-bit port b width ignores the endian choice
// (RULE_19) next port edges after primary release sample timing select
// (RULE_20) standard mode: empty and full flags, every word needs a read
// (RULE_21) fall-through mode: first word shows on port b without a read
// (RULE_22) system keeps endian/timing select static after reset
// (RULE_23) reset release counted per port domain before flags release
//
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "frm_regs.svh"

module frm_fifo_reset_config #(
	parameter int DEPTH = 256,
	parameter int AW    = 8,
	parameter int DW    = 36
) (
	input  wire logic          i_clk,
	input  wire logic          i_rst,
	input  wire logic          i_ce,
	input  wire logic          i_reset_primary_n,
	input  wire logic          i_reset_secondary_n,
	input  wire logic          i_partial_flush_n,
	input  wire logic          i_port_a_clock,
	input  wire logic          i_port_b_clock,
	input  wire logic          i_endian_timing_select,
	input  wire logic          i_flag_select0,
	input  wire logic          i_flag_select1,
	input  wire logic          i_serial_program_select_n,
	input  wire logic          i_a_write,
	input  wire logic [DW-1:0] i_a_data,
	input  wire logic          i_b_read,
	input  wire logic          i_mail_a_write,
	input  wire logic          i_mail_a_take,
	input  wire logic          i_mail_b_write,
	input  wire logic          i_mail_b_take,
	input  wire logic [3:0]    i_avs_address,
	input  wire logic          i_avs_read,
	input  wire logic          i_avs_write,
	input  wire logic [31:0]   i_avs_writedata,
	output logic [31:0]        o_avs_readdata,
	output logic               o_avs_waitrequest,
	output logic [DW-1:0]      o_b_data,
	output logic               o_full_input_ready_flag,
	output logic               o_empty_output_ready_flag,
	output logic               o_almost_empty_n,
	output logic               o_almost_full_n,
	output logic               o_mail_a_to_b_full_n,
	output logic               o_mail_b_to_a_full_n
);

	localparam int OW = AW + 1;
	localparam int HW = DW / 2;
	localparam int QW = DW / 4;

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [2:0]              sync1;
	logic [2:0]              sync2;
	logic                    a_prev;
	logic                    b_prev;
	logic [2:0]              cnt_a;
	logic [2:0]              cnt_b;
	logic                    hold_full;
	frm_pkg::frm_phase_type  phase;
	logic [1:0]              wake_cnt;
	logic                    big_endian;
	logic [2:0]              prog;
	logic                    fall_through_mode_a;
	logic                    fall_through_mode_b;
	logic                    pend_a;
	logic                    pend_b;
	logic [OW-1:0]           ofs_x;
	logic [OW-1:0]           ofs_y;
	logic [1:0]              load_cnt;
	logic [DW-1:0]           mem [DEPTH];
	logic [AW:0]             wptr;
	logic [AW:0]             rptr;
	logic [1:0]              unit_idx;
	logic [1:0]              bus_size;
	logic                    ack;
	logic                    fir;
	logic                    eor;
	logic                    ae_n;
	logic                    af_n;
	logic                    mba_n;
	logic                    mbb_n;
	logic                    prim_low;
	logic                    sec_low;
	logic                    part_low;
	logic                    any_low;
	logic                    a_edge;
	logic                    b_edge;
	logic                    qualified;
	logic                    release_ev;
	logic                    cfg_latch;
	logic                    run;
	logic                    wr_fire;
	logic                    wr_load;
	logic                    rd_fire;
	logic                    unit_last;
	logic [AW:0]             level;
	logic [AW:0]             next_level;
	logic [DW-1:0]           head_unit;
	logic [31:0]             next_readdata;

	// ------------------------------------------------------------------
	// reset input synchronisers
	// ------------------------------------------------------------------
	// two flops per reset pin; release of each is then seen in step
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1 <= 3'h0;
			sync2 <= 3'h0;
		end else if (i_ce) begin
			sync1 <= {i_partial_flush_n, i_reset_secondary_n,
				i_reset_primary_n}; // RULE_03
			sync2 <= sync1;
		end
	end

	assign prim_low = ~sync2[0];
	assign sec_low  = ~sync2[1];
	assign part_low = ~sync2[2];
	assign any_low  = prim_low | part_low;

	// port clock edge detection on sampled clock levels
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			a_prev <= 1'b0;
			b_prev <= 1'b0;
		end else if (i_ce) begin
			a_prev <= i_port_a_clock;
			b_prev <= i_port_b_clock;
		end
	end

	assign a_edge = i_ce & i_port_a_clock & ~a_prev;
	assign b_edge = i_ce & i_port_b_clock & ~b_prev;

	// ------------------------------------------------------------------
	// reset qualification and phase sequencing
	// ------------------------------------------------------------------
	// per-domain counts of port edges seen while the primary reset or the partial flush is held low
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_a <= 3'h0;
			cnt_b <= 3'h0;
		end else if (i_ce) begin
			if (!any_low) begin
				cnt_a <= 3'h0;
				cnt_b <= 3'h0;
			end else begin
				if (a_edge && cnt_a != `FRM_RESET_EDGES)
					cnt_a <= cnt_a + 3'h1; // RULE_23
				if (b_edge && cnt_b != `FRM_RESET_EDGES)
					cnt_b <= cnt_b + 3'h1; // RULE_23
			end
		end
	end

	assign qualified = (cnt_a == `FRM_RESET_EDGES) &&
		(cnt_b == `FRM_RESET_EDGES); // RULE_02 RULE_12
	assign release_ev = (phase == frm_pkg::FRM_PH_HOLD) && !any_low;
	assign cfg_latch  = release_ev && qualified && hold_full;
	assign run        = (phase == frm_pkg::FRM_PH_RUN);

	// remembers that the primary reset took part in this hold
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			hold_full <= 1'b0;
		else if (i_ce) begin
			if (phase != frm_pkg::FRM_PH_HOLD)
				hold_full <= 1'b0;
			else if (prim_low)
				hold_full <= 1'b1;
		end
	end

	// phase machine: hold while low, wake for two port a edges if qualified, then run
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			phase    <= frm_pkg::FRM_PH_HOLD;
			wake_cnt <= 2'h0;
		end else if (i_ce) begin
			if (any_low) begin
				phase    <= frm_pkg::FRM_PH_HOLD;
				wake_cnt <= 2'h0;
			end else begin
				unique case (phase)
				frm_pkg::FRM_PH_HOLD:
					phase <= qualified ? frm_pkg::FRM_PH_WAKE
						: frm_pkg::FRM_PH_RUN;
				frm_pkg::FRM_PH_WAKE: begin
					if (a_edge) begin
						wake_cnt <= wake_cnt + 2'h1;
						if (wake_cnt + 2'h1 == `FRM_RELEASE_EDGES)
							phase <= frm_pkg::FRM_PH_RUN; // RULE_07 RULE_14
					end
				end
				frm_pkg::FRM_PH_RUN: ;
				default: phase <= frm_pkg::FRM_PH_HOLD;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// configuration capture
	// ------------------------------------------------------------------
	// only a qualified full reset, or a parallel load write to the offsets, touches these; a flush keeps them
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			big_endian <= 1'b0;
			prog       <= `FRM_PROG_P64;
			ofs_x      <= OW'(`FRM_PRESET_64);
			ofs_y      <= OW'(`FRM_PRESET_64);
			load_cnt   <= 2'h0;
		end else if (i_ce) begin
			if (cfg_latch) begin // RULE_15
				big_endian <= i_endian_timing_select; // RULE_08
				prog <= {i_serial_program_select_n, i_flag_select1,
					i_flag_select0}; // RULE_09
				load_cnt <= 2'h0;
				unique case ({i_serial_program_select_n,
					i_flag_select1, i_flag_select0})
				`FRM_PROG_P64: begin
					ofs_x <= OW'(`FRM_PRESET_64); // RULE_10
					ofs_y <= OW'(`FRM_PRESET_64);
				end
				`FRM_PROG_P16: begin
					ofs_x <= OW'(`FRM_PRESET_16); // RULE_10
					ofs_y <= OW'(`FRM_PRESET_16);
				end
				`FRM_PROG_P8: begin
					ofs_x <= OW'(`FRM_PRESET_8); // RULE_10
					ofs_y <= OW'(`FRM_PRESET_8);
				end
				default: ; // parallel, serial, reserved keep
				endcase
			end else if (wr_load) begin
				load_cnt <= load_cnt + 2'h1;
				if (load_cnt == 2'h0)
					ofs_y <= i_a_data[OW-1:0]; // RULE_11
				else
					ofs_x <= i_a_data[OW-1:0]; // RULE_11
			end
		end
	end

	// timing mode taken on the first edge of each port after release
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			pend_a <= 1'b0;
			pend_b <= 1'b0;
			fall_through_mode_a <= 1'b0;
			fall_through_mode_b <= 1'b0;
		end else if (i_ce) begin
			if (cfg_latch) begin
				pend_a <= 1'b1;
				pend_b <= 1'b1;
			end else begin
				if (pend_a && a_edge) begin
					pend_a <= 1'b0;
					fall_through_mode_a <= ~i_endian_timing_select; // RULE_19
				end
				if (pend_b && b_edge) begin
					pend_b <= 1'b0;
					fall_through_mode_b <= ~i_endian_timing_select; // RULE_19 RULE_22
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// fifo storage and pointers
	// ------------------------------------------------------------------
	assign wr_fire = a_edge & run & fir & i_a_write;
	assign wr_load = wr_fire && (prog == `FRM_PROG_PARALLEL) &&
		(load_cnt != `FRM_PARALLEL_LOADS);
	assign rd_fire = b_edge & run & eor & i_b_read;
	assign level   = wptr - rptr;

	// unit of the head word that port b presents next
	always_comb begin
		head_unit = '0;
		unit_last = 1'b1;
		unique case (bus_size)
		frm_pkg::FRM_SIZE_18: begin
			unit_last = (unit_idx == 2'h1);
			head_unit[HW-1:0] = mem[rptr[AW-1:0]][(big_endian
				? 2'h1 - unit_idx : unit_idx) * HW +: HW]; // RULE_16 RULE_17
		end
		frm_pkg::FRM_SIZE_9: begin
			unit_last = (unit_idx == 2'h3);
			head_unit[QW-1:0] = mem[rptr[AW-1:0]][(big_endian
				? 2'h3 - unit_idx : unit_idx) * QW +: QW]; // RULE_16 RULE_17
		end
		default: head_unit = mem[rptr[AW-1:0]]; // RULE_18
		endcase
	end

	// level after this cycle's write and read
	always_comb begin
		next_level = level;
		if (wr_fire && !wr_load)
			next_level = next_level + (AW+1)'(1);
		if (rd_fire && unit_last)
			next_level = next_level - (AW+1)'(1);
	end

	// memory array write
	always_ff @(posedge i_clk) begin
		if (wr_fire && !wr_load)
			mem[wptr[AW-1:0]] <= i_a_data;
	end

	// pointers: a qualified hold clears them, data moves them
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			wptr     <= '0;
			rptr     <= '0;
			unit_idx <= 2'h0;
		end else if (i_ce) begin
			if (any_low && qualified) begin
				wptr     <= '0; // RULE_04 RULE_13
				rptr     <= '0;
				unit_idx <= 2'h0;
			end else begin
				if (wr_fire && !wr_load)
					wptr <= wptr + (AW+1)'(1);
				if (rd_fire) begin
					unit_idx <= unit_last ? 2'h0 : unit_idx + 2'h1;
					if (unit_last)
						rptr <= rptr + (AW+1)'(1);
				end
			end
		end
	end

	// port b data: on read in standard mode, continuously in fall-through
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_b_data <= '0;
		else if (i_ce) begin
			if (fall_through_mode_b)
				o_b_data <= head_unit; // RULE_21
			else if (rd_fire)
				o_b_data <= head_unit; // RULE_20
		end
	end

	// ------------------------------------------------------------------
	// flags
	// ------------------------------------------------------------------
	// full/input-ready, port a side
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			fir <= 1'b0;
		else if (i_ce) begin
			if (phase == frm_pkg::FRM_PH_HOLD)
				fir <= 1'b0; // RULE_04 RULE_13
			else if (phase == frm_pkg::FRM_PH_WAKE)
				fir <= a_edge &&
					(wake_cnt + 2'h1 == `FRM_RELEASE_EDGES); // RULE_07 RULE_14
			else if (a_edge)
				fir <= (next_level != (AW+1)'(DEPTH)); // RULE_20
		end
	end

	// empty/output-ready, port b side
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			eor <= 1'b0;
		else if (i_ce) begin
			if (!run)
				eor <= 1'b0; // RULE_04 RULE_13
			else if (b_edge)
				eor <= (next_level != '0); // RULE_20 RULE_21
		end
	end

	// almost-empty on port b, almost-full on port a
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ae_n <= 1'b0;
			af_n <= 1'b1;
		end else if (i_ce) begin
			if (any_low) begin
				ae_n <= 1'b0; // RULE_05 RULE_13
				af_n <= 1'b1;
			end else begin
				if (b_edge)
					ae_n <= (next_level > (AW+1)'(ofs_x));
				if (a_edge)
					af_n <= ((AW+1)'(DEPTH) - next_level > (AW+1)'(ofs_y));
			end
		end
	end

	// mailbox flags; a new write wins over a take in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mba_n <= 1'b1;
			mbb_n <= 1'b1;
		end else if (i_ce) begin
			if (prim_low || part_low)
				mba_n <= 1'b1; // RULE_05 RULE_06 RULE_13
			else if (a_edge && i_mail_a_write)
				mba_n <= 1'b0;
			else if (b_edge && i_mail_a_take)
				mba_n <= 1'b1;
			if (sec_low || part_low)
				mbb_n <= 1'b1; // RULE_05 RULE_06 RULE_13
			else if (b_edge && i_mail_b_write)
				mbb_n <= 1'b0;
			else if (a_edge && i_mail_b_take)
				mbb_n <= 1'b1;
		end
	end

	assign o_full_input_ready_flag   = fir;
	assign o_empty_output_ready_flag = eor;
	assign o_almost_empty_n          = ae_n;
	assign o_almost_full_n           = af_n;
	assign o_mail_a_to_b_full_n      = mba_n;
	assign o_mail_b_to_a_full_n      = mbb_n;

	// ------------------------------------------------------------------
	// avalon-mm register slave
	// ------------------------------------------------------------------
	// every access waits exactly one cycle
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

	always_comb begin
		next_readdata = 32'h0;
		unique case (i_avs_address)
		`FRM_REG_CONTROL: begin
			next_readdata[`FRM_CTL_SIZE_LSB +: 2] = bus_size;
		end
		`FRM_REG_STATUS: begin
			next_readdata[`FRM_ST_FIR]   = fir;
			next_readdata[`FRM_ST_EOR]   = eor;
			next_readdata[`FRM_ST_AE_N]  = ae_n;
			next_readdata[`FRM_ST_AF_N]  = af_n;
			next_readdata[`FRM_ST_MBA_N] = mba_n;
			next_readdata[`FRM_ST_MBB_N] = mbb_n;
			next_readdata[`FRM_ST_FALL_THROUGH_MODE_A] = fall_through_mode_a;
			next_readdata[`FRM_ST_FALL_THROUGH_MODE_B] = fall_through_mode_b;
			next_readdata[`FRM_ST_BIG]    = big_endian;
			next_readdata[`FRM_ST_PROG_LSB +: 3]  = prog;
			next_readdata[`FRM_ST_PHASE_LSB +: 3] = phase;
		end
		`FRM_REG_OFFSETS: begin
			next_readdata[`FRM_OFS_X_LSB +: OW] = ofs_x;
			next_readdata[`FRM_OFS_Y_LSB +: OW] = ofs_y;
		end
		`FRM_REG_LEVEL: begin
			next_readdata[AW:0] = level;
		end
		default: ; // unmapped offsets read zero
		endcase
	end

	// answer strobe and read data
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ack            <= 1'b0;
			o_avs_readdata <= 32'h0;
		end else if (i_ce) begin
			ack <= (i_avs_read | i_avs_write) & ~ack;
			if (i_avs_read && !ack)
				o_avs_readdata <= next_readdata;
		end
	end

	// control register: port b width
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			bus_size <= `FRM_CTL_RESET;
		else if (i_ce && i_avs_write && ack &&
			i_avs_address == `FRM_REG_CONTROL)
			bus_size <= i_avs_writedata[`FRM_CTL_SIZE_LSB +: 2];
	end

endmodule
`default_nettype wire

//--- dv/frm_port_partner.sv
// free-running port clocks of the two bus controllers
`timescale 1ns/1ps
`default_nettype none
module frm_port_partner #(
	parameter int PERIOD = 12
) (
	input  wire logic i_clk,
	output logic      o_port_a_clock,
	output logic      o_port_b_clock
);
	int cnt = 0;

	// -------------------------------------------------
	// period counter, port b rises one cycle after a
	// -------------------------------------------------
	always @(posedge i_clk)
		cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;

	// both clocks keep running through every reset hold
	assign o_port_a_clock = cnt < PERIOD / 2;
	assign o_port_b_clock = cnt >= 1 && cnt <= PERIOD / 2;
endmodule
`default_nettype wire

//--- dv/frm_fifo_reset_config_sva.sv
// assertion checker of the fifo reset and configuration block
`timescale 1ns/1ps
`default_nettype none
module frm_fifo_reset_config_sva (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic        i_ce,
	input wire logic        i_reset_primary_n,
	input wire logic        i_reset_secondary_n,
	input wire logic        i_partial_flush_n,
	input wire logic        i_port_a_clock,
	input wire logic        i_avs_read,
	input wire logic        i_avs_write,
	input wire logic        o_avs_waitrequest,
	input wire logic [31:0] o_avs_readdata,
	input wire logic        o_full_input_ready_flag,
	input wire logic        o_almost_empty_n,
	input wire logic        o_almost_full_n,
	input wire logic        o_mail_a_to_b_full_n,
	input wire logic        o_mail_b_to_a_full_n
);
	logic       a_prev;
	logic [1:0] a_cnt;
	wire logic  req = i_avs_read || i_avs_write;
	wire logic  fir = o_full_input_ready_flag;

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst || !i_ce);

	// -------------------------------------------------
	// raw port a edges since both pins went high
	// -------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			a_prev <= 1'b0;
			a_cnt <= 2'h0;
		end else begin
			a_prev <= i_port_a_clock;
			if (!i_reset_primary_n || !i_partial_flush_n)
				a_cnt <= 2'h0;
			else if (i_port_a_clock && !a_prev && a_cnt != 2'h3)
				a_cnt <= a_cnt + 2'h1;
		end
	end

	// -------------------------------------------------
	// assertions
	// -------------------------------------------------
	chk_reset_flag_force : assert property (
		$fell(i_reset_primary_n) |-> ##[1:4] (!o_almost_empty_n &&
		o_almost_full_n && o_mail_a_to_b_full_n))
		else $error("flags not forced by primary reset");
	chk_second_mail_clear : assert property (
		$fell(i_reset_secondary_n) |-> ##[1:4] o_mail_b_to_a_full_n)
		else $error("b to a mail flag not forced");
	chk_reset_not_ready : assert property (
		(!i_reset_primary_n) [*5] |-> !fir)
		else $error("ready during primary reset");
	chk_flush_flag_state : assert property (
		(!i_partial_flush_n) [*5] |-> !fir && !o_almost_empty_n &&
		o_almost_full_n && o_mail_a_to_b_full_n && o_mail_b_to_a_full_n)
		else $error("flags wrong during flush");
	chk_ready_port_edges : assert property (
		$rose(fir) |-> a_cnt != 2'h0)
		else $error("ready rose without a port a edge");
	chk_reset_release : assert property (
		$rose(i_reset_primary_n) && i_partial_flush_n |->
		!fir [*3] ##[1:37] fir)
		else $error("ready timing after reset wrong");
	chk_flush_release : assert property (
		$rose(i_partial_flush_n) && i_reset_primary_n |->
		!fir [*3] ##[1:37] fir)
		else $error("ready timing after flush wrong");
	chk_wait_one_cycle : assert property (
		$rose(req) |-> o_avs_waitrequest ##1 !o_avs_waitrequest)
		else $error("waitrequest not one cycle");
	chk_read_data_hold : assert property (
		$changed(o_avs_readdata) |-> $past(i_avs_read))
		else $error("read data changed without read");
endmodule

bind frm_fifo_reset_config frm_fifo_reset_config_sva u_sva (.*);
`default_nettype wire

//--- dv/fifo_reset_and_mode_config_bench.sv
// self-checking testbench of the fifo reset and configuration block
`timescale 1ns/1ps
`default_nettype none
module fifo_reset_and_mode_config_bench;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        rp_n = 1'b1;
	logic        rs_n = 1'b1;
	logic        pf_n = 1'b1;
	logic        ets = 1'b0;
	logic        fs0 = 1'b0;
	logic        fs1 = 1'b0;
	logic        spm_n = 1'b0;
	logic        a_wr = 1'b0;
	logic [35:0] a_data = 36'h0;
	logic        b_rd = 1'b0;
	logic [3:0]  av_a = 4'h0;
	logic        av_rd = 1'b0;
	logic        av_wr = 1'b0;
	logic [31:0] av_wd = 32'h0;
	logic [31:0] rdata;
	logic        waitreq;
	logic [35:0] b_data;
	logic        pac, pbc, fir, eor, ae_n, af_n, mba_n, mbb_n;
	int          error_cnt = 0;
	int          num_checks = 0;

	always #2.5 clk = ~clk;

	frm_port_partner u_partner (.i_clk(clk), .o_port_a_clock(pac),
		.o_port_b_clock(pbc));

	frm_fifo_reset_config uut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1),
		.i_reset_primary_n(rp_n), .i_reset_secondary_n(rs_n),
		.i_partial_flush_n(pf_n), .i_port_a_clock(pac),
		.i_port_b_clock(pbc), .i_endian_timing_select(ets),
		.i_flag_select0(fs0), .i_flag_select1(fs1),
		.i_serial_program_select_n(spm_n), .i_a_write(a_wr),
		.i_a_data(a_data), .i_b_read(b_rd), .i_mail_a_write(1'b0),
		.i_mail_a_take(1'b0), .i_mail_b_write(1'b0), .i_mail_b_take(1'b0),
		.i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr),
		.i_avs_writedata(av_wd), .o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq), .o_b_data(b_data),
		.o_full_input_ready_flag(fir), .o_empty_output_ready_flag(eor),
		.o_almost_empty_n(ae_n), .o_almost_full_n(af_n),
		.o_mail_a_to_b_full_n(mba_n), .o_mail_b_to_a_full_n(mbb_n));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [35:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		av_rd <= !w;
		av_wr <= w;
		av_a <= a;
		av_wd <= wd;
		do @(posedge clk); while (waitreq !== 1'b0);
		rd = rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clk);
	endtask

	// write (b=0) or read (b=1) held across exactly one port edge
	task automatic on_edge(input bit b, input logic [35:0] d);
		if (b) @(posedge pbc); else @(posedge pac);
		repeat (2) @(posedge clk);
		b_rd <= b;
		a_wr <= !b;
		a_data <= d;
		if (b) @(posedge pbc); else @(posedge pac);
		repeat (2) @(posedge clk);
		b_rd <= 1'b0;
		a_wr <= 1'b0;
	endtask

	// full reset or flush with held selects, then wait for ready
	task automatic pin_reset(input bit full, input logic [2:0] prog,
		input logic big, tm);
		int n;
		if (full) begin
			rp_n <= 1'b0;
			rs_n <= 1'b0;
			ets <= big;
		end else
			pf_n <= 1'b0;
		{spm_n, fs1, fs0} <= prog;
		repeat (60) @(posedge clk);
		chk("hold flags", {fir, eor, ae_n, af_n, mba_n, mbb_n}, 6'h07);
		@(posedge pbc);
		rp_n <= 1'b1;
		rs_n <= 1'b1;
		pf_n <= 1'b1;
		repeat (6) @(posedge clk);
		if (full) ets <= tm;
		for (n = 0; n < 40 && fir !== 1'b1; n++) @(posedge clk);
		chk("ready", fir, 1'b1);
	endtask

	task automatic chk_cfg(input logic [2:0] prog, input logic big, tm);
		logic [31:0] d;
		bus(1'b0, 4'h4, 32'h0, d);
		chk("config", d[11:6], {prog, big, !tm, !tm});
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// every select code latched on release, presets loaded
	task automatic t_codes;
		logic [31:0] d;
		logic [8:0]  o;
		for (int c = 0; c < 8; c++) begin
			pin_reset(1'b1, c[2:0], c[0], 1'b1);
			chk_cfg(c[2:0], c[0], 1'b1);
			o = c == 7 ? 9'h040 : c == 6 ? 9'h010 : 9'h008;
			if (c >= 5) begin
				bus(1'b0, 4'h8, 32'h0, d);
				chk("offsets", d, {7'h0, o, 7'h0, o});
			end
		end
		bus(1'b0, 4'h2, 32'h0, d);
		chk("unmapped", d, 32'h0);
	endtask

	// parallel offset load, then a flush that keeps it
	task automatic t_parallel;
		logic [31:0] d;
		pin_reset(1'b1, 3'h4, 1'b1, 1'b1);
		on_edge(1'b0, 36'h0a3);
		on_edge(1'b0, 36'h05c);
		on_edge(1'b0, 36'h9_8765_4321);
		bus(1'b0, 4'h8, 32'h0, d);
		chk("loaded", d, 32'h00a3_005c);
		bus(1'b0, 4'hc, 32'h0, d);
		chk("level", d[8:0], 9'h001);
		pin_reset(1'b0, 3'h7, 1'b0, 1'b1);
		chk_cfg(3'h4, 1'b1, 1'b1);
		bus(1'b0, 4'h8, 32'h0, d);
		chk("kept", d, 32'h00a3_005c);
		bus(1'b0, 4'hc, 32'h0, d);
		chk("flushed", d[8:0], 9'h000);
	endtask

	// one word out of port b unit by unit in standard mode
	task automatic t_units(input logic [1:0] sz, input logic big,
		input logic [35:0] w);
		logic [31:0] d;
		int n;
		n = sz == 2'h1 ? 2 : sz == 2'h2 ? 4 : 1;
		bus(1'b1, 4'h0, {30'h0, sz}, d);
		on_edge(1'b0, w);
		chk("held back", b_data === w, 1'b0);
		for (int u = 0; u < n; u++) begin
			on_edge(1'b1, 36'h0);
			chk("unit", b_data, (w >> ((big ? n - 1 - u : u) * (36 / n))) & ~(36'hf_ffff_ffff << (36 / n)));
		end
	endtask

	// fall-through mode shows the first word without a read
	task automatic t_fall_through_mode;
		logic [31:0] d;
		int n;
		pin_reset(1'b1, 3'h7, 1'b0, 1'b0);
		chk_cfg(3'h7, 1'b0, 1'b0);
		bus(1'b1, 4'h0, 32'h0, d);
		on_edge(1'b0, 36'h6_0f0f_a5a5);
		for (n = 0; n < 40 && eor !== 1'b1; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		chk("output ready", eor, 1'b1);
		chk("fall through", b_data, 36'h6_0f0f_a5a5);
		pin_reset(1'b0, 3'h5, 1'b1, 1'b1);
		chk_cfg(3'h7, 1'b0, 1'b0);
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		t_codes;
		t_parallel;
		t_units(2'h1, 1'b1, 36'h9_1234_5678);
		t_units(2'h0, 1'b1, 36'h3_8765_4321);
		pin_reset(1'b1, 3'h7, 1'b0, 1'b1);
		t_units(2'h2, 1'b0, 36'h4_a1b2_c3d5);
		t_fall_through_mode;
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop;
	end
endmodule
`default_nettype wire
